//--- core/pin_sync_if.sv
// Carrier for raw and synchronised pin levels
`timescale 1ns/1ns
interface pin_sync_if;
    logic pin_raw;
    logic hv_raw;
    logic pin_sync;
    logic hv_sync;
    modport sync (input pin_raw, input hv_raw, output pin_sync, output hv_sync);
    modport user (output pin_raw, output hv_raw, input pin_sync, input hv_sync);
endinterface

//--- core/pin_synchroniser.sv
// Two-stage synchroniser for the pad level and high-voltage detector
`timescale 1ns/1ns
module pin_synchroniser (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    pin_sync_if.sync  bus
);
    logic [1:0] pin_stage;
    logic [1:0] hv_stage;

    // Pad idles high through the pull-up, so reset to one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_stage <= 2'h3;
            hv_stage  <= 2'h0;
        end else begin
            pin_stage <= {pin_stage[0], bus.pin_raw};
            hv_stage  <= {hv_stage[0], bus.hv_raw};
        end
    end

    assign bus.pin_sync = pin_stage[1];
    assign bus.hv_sync  = hv_stage[1];
endmodule // pin_synchroniser

//--- core/reset_pin_debug_mux.sv
// Fuse-driven function selector for the shared reset/programming pin
`timescale 1ns/1ns
`include "reset_pin_debug_mux_regs.svh"
module reset_pin_debug_mux (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_por_done,
    input  wire logic [1:0] i_reset_pin_function_fuse,
    input  wire logic       i_single_pin_debug_enable_fuse,
    input  wire logic       i_serial_program_enable_fuse,
    input  wire logic       i_lock_bits_programmed,
    input  wire logic       i_chip_erase_done,
    input  wire logic       i_pin_in,
    input  wire logic       i_hv_detect,
    input  wire logic       i_gpio_out,
    input  wire logic       i_gpio_oe,
    input  wire logic       i_debug_drive_low,
    input  wire logic       i_debug_self_disable,
    input  wire logic       i_one_wire_tx_low,
    input  wire logic       i_serial_op_valid,
    input  wire logic [1:0] i_serial_op,
    output logic            o_pin_out,
    output logic            o_pin_oe,
    output logic            o_pin_pullup,
    output logic            o_gpio_in,
    output logic            o_ext_reset_b,
    output logic            o_one_wire_program_port_en,
    output logic            o_one_wire_rx,
    output logic            o_single_pin_debug_link_en,
    output logic            o_debug_rx,
    output logic            o_serial_port_en,
    output logic            o_serial_op_accept,
    output logic            o_serial_op_reject
);
    pin_sync_if sync_bus ();

    logic       fuse_captured;
    logic [1:0] pin_fuse;
    logic       dbg_fuse;
    logic       ser_fuse;
    logic       onewire_unlocked;
    logic       self_disabled;
    logic       hv_prev;
    logic       link_active;
    logic       limited;
    logic       op_allowed;
    reset_pin_debug_mux_pkg::pin_role_type role;

    // Role test shared by the one-wire enable, reset and receive paths
    function automatic logic role_is(input reset_pin_debug_mux_pkg::pin_role_type now_role,
                                     input reset_pin_debug_mux_pkg::pin_role_type want_role);
        return now_role == want_role;
    endfunction

    // Operations still served while the debug fuse keeps the serial port limited
    function automatic logic limited_op_ok(input logic [1:0] code);
        return (code == `SER_OP_FUSE_READ) || (code == `SER_OP_SIG_READ)
               || (code == `SER_OP_ERASE);
    endfunction

    // Raw pad and detector levels enter the two-flop synchroniser
    assign sync_bus.pin_raw = i_pin_in;
    assign sync_bus.hv_raw  = i_hv_detect;

    pin_synchroniser u_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .bus     (sync_bus)
    );

    // Fuses caught once after power-up; reset may only load constants
    // Fuse values stay put until the next power cycle, so no resync is needed
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fuse_captured <= 1'h0;
            pin_fuse      <= `PIN_FUSE_RESET;
            dbg_fuse      <= 1'h0;
            ser_fuse      <= 1'h0;
        end else if (i_por_done && !fuse_captured) begin
            fuse_captured <= 1'h1;
            pin_fuse      <= i_reset_pin_function_fuse;
            dbg_fuse      <= i_single_pin_debug_enable_fuse;
            ser_fuse      <= i_serial_program_enable_fuse;
        end
    end

    // Rising edge of the high-voltage detector reopens the one-wire port
    // Detector pulse may be long; only its first edge counts
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hv_prev          <= 1'h0;
            onewire_unlocked <= 1'h0;
        end else begin
            hv_prev <= sync_bus.hv_sync;
            if (sync_bus.hv_sync && !hv_prev && fuse_captured) begin
                onewire_unlocked <= 1'h1; // RULE4
            end
        end
    end

    // Self-disable held until the next power cycle clears it
    // Limitation: only a power-on reset lets the link take the pin back
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            self_disabled <= 1'h0; // RULE10
        end else if (link_active && i_debug_self_disable) begin
            self_disabled <= 1'h1; // RULE9
        end
    end

    // Debug live only with fuse set, lock clear; lock is read live so an erase re-enables it
    assign link_active = fuse_captured && dbg_fuse && !i_lock_bits_programmed
                         && !self_disabled; // RULE6 RULE11 RULE12

    // Pin role selection, debug link overriding the fuse field
    // Reserved code falls to the reset input so a bad fuse never strands the pin
    always_comb begin
        if (link_active) begin
            role = reset_pin_debug_mux_pkg::PIN_DEBUG; // RULE8
        end else if (onewire_unlocked) begin
            role = reset_pin_debug_mux_pkg::PIN_ONEWIRE; // RULE4
        end else begin
            unique case (pin_fuse)
                `PIN_FUSE_GPIO:    role = reset_pin_debug_mux_pkg::PIN_GPIO; // RULE1
                `PIN_FUSE_ONEWIRE: role = reset_pin_debug_mux_pkg::PIN_ONEWIRE; // RULE2
                `PIN_FUSE_RESET:   role = reset_pin_debug_mux_pkg::PIN_RESET; // RULE3
                default:           role = reset_pin_debug_mux_pkg::PIN_RESET; // RULE14
            endcase
        end
    end

    // Pad drive: open-drain for both single-pin links, so only zeros are driven
    // Pull-up stays on outside GPIO so an idle link or reset pin reads high
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_out    <= 1'h0;
            o_pin_oe     <= 1'h0;
            o_pin_pullup <= 1'h1;
        end else begin
            unique case (role)
                reset_pin_debug_mux_pkg::PIN_GPIO: begin
                    o_pin_out    <= i_gpio_out; // RULE1
                    o_pin_oe     <= i_gpio_oe;
                    o_pin_pullup <= 1'h0;
                end
                reset_pin_debug_mux_pkg::PIN_ONEWIRE: begin
                    o_pin_out    <= 1'h0; // RULE5
                    o_pin_oe     <= i_one_wire_tx_low;
                    o_pin_pullup <= 1'h1;
                end
                reset_pin_debug_mux_pkg::PIN_RESET: begin
                    o_pin_out    <= 1'h0;
                    o_pin_oe     <= 1'h0;
                    o_pin_pullup <= 1'h1;
                end
                reset_pin_debug_mux_pkg::PIN_DEBUG: begin
                    o_pin_out    <= 1'h0; // RULE7
                    o_pin_oe     <= i_debug_drive_low;
                    o_pin_pullup <= 1'h1;
                end
            endcase
        end
    end

    // Role enables, registered so each output is a clean level
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_one_wire_program_port_en <= 1'h0;
            o_single_pin_debug_link_en <= 1'h0;
            o_serial_port_en           <= 1'h0;
        end else begin
            o_one_wire_program_port_en <= role_is(role, reset_pin_debug_mux_pkg::PIN_ONEWIRE);
            o_single_pin_debug_link_en <= link_active; // RULE7
            // Serial port usable only with its fuse and the debug link off
            o_serial_port_en <= fuse_captured && ser_fuse && !link_active; // RULE8 RULE9
        end
    end

    // Received pad level fed to the GPIO input always, to the other functions only while they own the pin
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_gpio_in     <= 1'h1;
            o_ext_reset_b <= 1'h1;
            o_one_wire_rx <= 1'h1;
            o_debug_rx    <= 1'h1;
        end else begin
            o_gpio_in     <= sync_bus.pin_sync;
            // Only the reset role forwards a reset; the others never hold the core
            o_ext_reset_b <= role_is(role, reset_pin_debug_mux_pkg::PIN_RESET)
                             ? sync_bus.pin_sync : 1'h1; // RULE3 RULE2
            o_one_wire_rx <= role_is(role, reset_pin_debug_mux_pkg::PIN_ONEWIRE)
                             ? sync_bus.pin_sync : 1'h1; // RULE5
            o_debug_rx    <= link_active ? sync_bus.pin_sync : 1'h1;
        end
    end

    // Limited state: debug fuse set but link not in control of the pin
    // Port enable is registered, so a verdict sees the port state one cycle old
    assign limited    = dbg_fuse && !link_active;
    assign op_allowed = limited_op_ok(i_serial_op);

    // One-cycle verdict per serial operation request
    // Exactly one of the two pulses answers each valid request
    // Refused when the port is off, or limited and the code is not served
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_serial_op_accept <= 1'h0;
            o_serial_op_reject <= 1'h0;
        end else begin
            o_serial_op_accept <= i_serial_op_valid && o_serial_port_en
                                  && (!limited || op_allowed); // RULE13
            o_serial_op_reject <= i_serial_op_valid
                                  && (!o_serial_port_en || (limited && !op_allowed)); // RULE13
        end
    end

    // Chip erase is noted only through the live lock input
    logic unused_erase;
    assign unused_erase = i_chip_erase_done;
endmodule // reset_pin_debug_mux

//--- core/reset_pin_debug_mux_pkg.sv
// Types for the shared reset/debug pin selector
package reset_pin_debug_mux_pkg;
    typedef enum logic [3:0] {
        PIN_GPIO    = 4'h1,
        PIN_ONEWIRE = 4'h2,
        PIN_RESET   = 4'h4,
        PIN_DEBUG   = 4'h8
    } pin_role_type;
endpackage

//--- core/reset_pin_debug_mux_regs.svh
// Constants for the shared reset/debug pin selector
// How it works
// RULE1: Fuse 00 makes pin plain GPIO
// RULE2: Fuse 01 dedicates pin to one-wire port
// RULE3: Fuse 10 makes pin reset input
// RULE4: High-voltage pulse reopens one-wire port
// RULE5: One-wire port is half-duplex single pin
// RULE6: Debug needs enable fuse, lock clear
// RULE7: Debug drives pin open-drain with pull-up
// RULE8: Debug enable fuse overrides serial port
// RULE9: Debug self-disable frees pin, needs serial fuse
// RULE10: Power cycle ends debug self-disable
// RULE11: Programmed lock bits refuse debug link
// RULE12: Chip erase clearing locks re-enables debug
// RULE13: Limited state allows fuse, signature, erase
// RULE14: Reserved fuse code 11 acts as reset
`ifndef RESET_PIN_DEBUG_MUX_REGS_SVH
`define RESET_PIN_DEBUG_MUX_REGS_SVH
`define PIN_FUSE_GPIO    2'h0
`define PIN_FUSE_ONEWIRE 2'h1
`define PIN_FUSE_RESET   2'h2
`define PIN_FUSE_RSVD    2'h3
`define SER_OP_FUSE_READ 2'h1
`define SER_OP_SIG_READ  2'h2
`define SER_OP_ERASE     2'h3
`define SYNC_STAGES      2
`endif

//--- testbench/debug_tool_model.sv
// Behavioural programmer and debugger tool on the shared pin
`timescale 1ns/1ns
module debug_tool_model (
    input  wire logic i_clk,
    input  wire logic i_pin_oe,
    input  wire logic i_pin_out,
    input  wire logic i_pin_pullup,
    input  wire logic i_tool_low,
    input  wire logic i_tool_hv,
    output logic      o_pin_level,
    output logic      o_hv_detect
);
    logic floating = 1'h0;
    // Wired-AND line: any sink wins, half-duplex by nature
    always_comb begin
        if ((i_pin_oe && !i_pin_out) || i_tool_low) o_pin_level = 1'h0;
        else if (i_pin_oe || i_pin_pullup) o_pin_level = 1'h1;
        else o_pin_level = floating;
    end
    // Undriven pad must not keep a stale level
    always @(posedge i_clk) floating <= ~o_pin_level;
    assign o_hv_detect = i_tool_hv;
endmodule // debug_tool_model

//--- testbench/reset_pin_debug_mux_assertions.sv
// Concurrent checks on the shared pin selector ports
`timescale 1ns/1ns
module reset_pin_debug_mux_assertions (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_por_done,
    input wire logic [1:0] i_reset_pin_function_fuse,
    input wire logic       i_single_pin_debug_enable_fuse,
    input wire logic       i_serial_program_enable_fuse,
    input wire logic       i_lock_bits_programmed,
    input wire logic       i_hv_detect,
    input wire logic       i_debug_self_disable,
    input wire logic       i_serial_op_valid,
    input wire logic [1:0] i_serial_op,
    input wire logic       o_pin_out,
    input wire logic       o_pin_pullup,
    input wire logic       o_ext_reset_b,
    input wire logic       o_one_wire_program_port_en,
    input wire logic       o_single_pin_debug_link_en,
    input wire logic       o_serial_port_en,
    input wire logic       o_serial_op_accept,
    input wire logic       o_serial_op_reject
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Fuses captured and role settled, debug fuse clear
    sequence s_ready;
        i_por_done && $past(i_por_done, 2) && !i_single_pin_debug_enable_fuse;
    endsequence
    a_gpio_no_reset: assert property (s_ready ##0 i_reset_pin_function_fuse == 2'h0 |-> o_ext_reset_b) else $error("reset seen in gpio role");
    a_onewire_dedicated: assert property (s_ready ##0 i_reset_pin_function_fuse == 2'h1 |-> o_one_wire_program_port_en && o_ext_reset_b) else $error("one-wire role missing");
    a_hv_unlock: assert property (s_ready ##0 $rose(i_hv_detect) |-> ##[1:5] o_one_wire_program_port_en) else $error("pulse did not open one-wire");
    a_debug_gate: assert property (o_single_pin_debug_link_en |-> i_single_pin_debug_enable_fuse && !$past(i_lock_bits_programmed)) else $error("debug link without fuse or with lock");
    a_erase_relink: assert property (i_por_done && $past(i_por_done, 2) && i_single_pin_debug_enable_fuse && $fell(i_lock_bits_programmed) |-> ##1 o_single_pin_debug_link_en) else $error("link not back after unlock");
    a_open_drain: assert property (o_single_pin_debug_link_en |-> o_pin_pullup && !o_pin_out && !o_serial_port_en) else $error("debug pin not open-drain");
    a_self_release: assert property (o_single_pin_debug_link_en && i_debug_self_disable |-> ##2 !o_single_pin_debug_link_en && o_serial_port_en == i_serial_program_enable_fuse) else $error("self-disable wrong");
    a_verdict_pair: assert property ((o_serial_op_accept ^ o_serial_op_reject) == $past(i_serial_op_valid)) else $error("verdict pulse wrong");
    a_limited_ops: assert property (i_serial_op_valid && i_single_pin_debug_enable_fuse && i_serial_op == 2'h0 |=> o_serial_op_reject) else $error("other op accepted");
endmodule // reset_pin_debug_mux_assertions

//--- testbench/reset_pin_debug_mux_tb.sv
// Self-checking bench for the shared reset/debug pin selector
`timescale 1ns/1ns
module reset_pin_debug_mux_tb;
    logic i_clk, i_rst_b, i_por_done, i_single_pin_debug_enable_fuse, i_chip_erase_done;
    logic i_serial_program_enable_fuse, i_lock_bits_programmed, i_pin_in, i_hv_detect;
    logic i_gpio_out, i_gpio_oe, i_debug_drive_low, i_debug_self_disable, i_one_wire_tx_low;
    logic i_serial_op_valid, o_pin_out, o_pin_oe, o_pin_pullup, o_gpio_in, o_ext_reset_b;
    logic o_one_wire_program_port_en, o_one_wire_rx, o_single_pin_debug_link_en, o_debug_rx;
    logic o_serial_port_en, o_serial_op_accept, o_serial_op_reject, tool_low, tool_hv;
    logic [1:0] i_reset_pin_function_fuse, i_serial_op;
    int   num_errors = 0;
    int   total_checks = 0;
    reset_pin_debug_mux reset_pin_debug_mux_i (.i_clk, .i_rst_b, .i_por_done,
        .i_reset_pin_function_fuse, .i_single_pin_debug_enable_fuse, .i_chip_erase_done,
        .i_serial_program_enable_fuse, .i_lock_bits_programmed, .i_pin_in, .i_hv_detect,
        .i_gpio_out, .i_gpio_oe, .i_debug_drive_low, .i_debug_self_disable, .i_serial_op,
        .i_one_wire_tx_low, .i_serial_op_valid, .o_pin_out, .o_pin_oe, .o_pin_pullup,
        .o_gpio_in, .o_ext_reset_b, .o_one_wire_program_port_en, .o_one_wire_rx,
        .o_single_pin_debug_link_en, .o_debug_rx, .o_serial_port_en, .o_serial_op_accept,
        .o_serial_op_reject);
    debug_tool_model debug_tool_model_i (.i_clk, .i_pin_oe(o_pin_oe), .i_pin_out(o_pin_out),
        .i_pin_pullup(o_pin_pullup), .i_tool_low(tool_low), .i_tool_hv(tool_hv),
        .o_pin_level(i_pin_in), .o_hv_detect(i_hv_detect));
    // Clock at 4 ns period
    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    // Sample one step after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Power cycle with new fuses; por_done low during reset so capture is fresh
    task automatic boot(input logic [1:0] fuse, input logic dbg, ser, lock);
        @(posedge i_clk);
        {i_rst_b, i_por_done, i_gpio_oe, i_debug_self_disable, tool_low, tool_hv} <= 6'h00;
        {i_reset_pin_function_fuse, i_single_pin_debug_enable_fuse} <= {fuse, dbg};
        {i_serial_program_enable_fuse, i_lock_bits_programmed} <= {ser, lock};
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clk);
        i_por_done <= 1'h1;
        cyc(5);
    endtask
    task automatic op(input logic [1:0] code, input logic acc);
        @(posedge i_clk);
        {i_serial_op_valid, i_serial_op} <= {1'h1, code};
        @(posedge i_clk);
        i_serial_op_valid <= 1'h0;
        #1;
        chk(o_serial_op_accept, acc);
        chk(o_serial_op_reject, !acc);
    endtask
    task automatic t_gpio;
        boot(2'h0, 1'h0, 1'h1, 1'h0);
        {i_gpio_oe, i_gpio_out} <= 2'h3;
        cyc(4);
        chk(o_pin_out, 1'h1);
        chk(o_gpio_in, 1'h1);
        chk(o_ext_reset_b, 1'h1);
        i_gpio_out <= 1'h0;
        cyc(4);
        chk(o_gpio_in, 1'h0);
        chk(o_one_wire_program_port_en, 1'h0);
        tool_hv <= 1'h1;
        cyc(6);
        chk(o_one_wire_program_port_en, 1'h1);
    endtask
    task automatic t_onewire;
        boot(2'h1, 1'h0, 1'h1, 1'h0);
        chk(o_one_wire_program_port_en, 1'h1);
        tool_low <= 1'h1;
        cyc(4);
        chk(o_one_wire_rx, 1'h0);
        chk(o_ext_reset_b, 1'h1);
        {tool_low, i_one_wire_tx_low} <= 2'h1;
        cyc(2);
        chk(o_pin_oe && !o_pin_out, 1'h1);
        i_one_wire_tx_low <= 1'h0;
    endtask
    // Reset role, also for the reserved code
    task automatic t_reset(input logic [1:0] fuse);
        boot(fuse, 1'h0, 1'h1, 1'h0);
        tool_low <= 1'h1;
        cyc(4);
        chk(o_ext_reset_b, 1'h0);
        chk(o_one_wire_program_port_en, 1'h0);
    endtask
    task automatic t_debug;
        boot(2'h0, 1'h1, 1'h1, 1'h0);
        chk(o_single_pin_debug_link_en && o_pin_pullup, 1'h1);
        chk(o_serial_port_en, 1'h0);
        op(2'h1, 1'h0);
        i_debug_drive_low <= 1'h1;
        cyc(4);
        chk(o_debug_rx, 1'h0);
        i_debug_drive_low <= 1'h0;
        cyc(4);
        chk(o_debug_rx, 1'h1);
        i_debug_self_disable <= 1'h1;
        cyc(2);
        chk(o_serial_port_en && !o_single_pin_debug_link_en, 1'h1);
        for (int c = 0; c < 4; c++) op(c[1:0], c != 0);
    endtask
    task automatic t_noser;
        boot(2'h0, 1'h1, 1'h0, 1'h0);
        chk(o_single_pin_debug_link_en, 1'h1);
        i_debug_self_disable <= 1'h1;
        cyc(2);
        chk(o_serial_port_en, 1'h0);
        chk(o_single_pin_debug_link_en, 1'h0);
        op(2'h1, 1'h0);
    endtask
    task automatic t_lock;
        boot(2'h0, 1'h1, 1'h1, 1'h1);
        chk(o_single_pin_debug_link_en, 1'h0);
        i_lock_bits_programmed <= 1'h0;
        cyc(2);
        chk(o_single_pin_debug_link_en, 1'h1);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run is under two hundred cycles; this bound is generous
    initial begin
        #40000;
        num_errors++;
        results();
    end
    initial begin
        {i_rst_b, i_por_done, i_single_pin_debug_enable_fuse, i_chip_erase_done} = 4'h0;
        {i_serial_program_enable_fuse, i_lock_bits_programmed, i_gpio_out, i_gpio_oe} = 4'h0;
        {i_debug_drive_low, i_debug_self_disable, i_one_wire_tx_low, i_serial_op_valid} = 4'h0;
        {tool_low, tool_hv, i_reset_pin_function_fuse, i_serial_op} = 6'h00;
        t_gpio();
        t_onewire();
        t_reset(2'h2);
        t_reset(2'h3);
        t_debug();
        t_noser();
        t_lock();
        results();
    end
endmodule // reset_pin_debug_mux_tb
bind reset_pin_debug_mux reset_pin_debug_mux_assertions reset_pin_debug_mux_assertions_i (
    .i_clk, .i_rst_b, .i_por_done, .i_reset_pin_function_fuse, .i_serial_op_valid,
    .i_single_pin_debug_enable_fuse, .i_serial_program_enable_fuse, .i_lock_bits_programmed,
    .i_hv_detect, .i_debug_self_disable, .i_serial_op, .o_pin_out, .o_pin_pullup,
    .o_ext_reset_b, .o_one_wire_program_port_en, .o_single_pin_debug_link_en,
    .o_serial_port_en, .o_serial_op_accept, .o_serial_op_reject);
